/* bench/pmtr_asserts.sv */
`timescale 1ns/1ps
module pmtr_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input pmtr_pkg::pmtr_cpu_req_s cpu_req,
  input wire logic [9:0] fetch_addr,
  input wire logic instr_cycle,
  input wire logic cpu_stall,
  input pmtr_pkg::pmtr_dm_wr_s dm_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic port_a_bit_two_pin_oe,
  input wire logic prog_active
);
  import pmtr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // fetch side: reset start, plain step, branch load, boundary spacing
  a_reset_pc: assert property ($rose(rst_n) |-> !instr_cycle [*2] ##[1:3]
    (instr_cycle && fetch_addr == 10'h001)) else $error("pc did not start at zero");
  a_fetch_step: assert property (instr_cycle && $past(instr_cycle, 4) && !$past(cpu_stall)
    && !$past(cpu_req.branch) && !$past(cpu_req.tbl_req)
    |-> fetch_addr == 10'($past(fetch_addr) + 10'h001)) else $error("pc did not step");
  a_branch_load: assert property (instr_cycle && $past(cpu_req.branch) && !$past(cpu_stall)
    && !$past(prog_active) |-> fetch_addr == $past(cpu_req.branch_addr))
    else $error("branch target not loaded");
  a_instr_period: assert property (instr_cycle |=> !instr_cycle [*3] ##1
    (instr_cycle || prog_active)) else $error("boundary spacing wrong");
  // table read: one stalled cycle, then the byte write and latch load
  a_stall_len: assert property ($rose(cpu_stall) && instr_cycle && !prog_active
    |-> cpu_stall [*4] ##1 !cpu_stall) else $error("table stall length wrong");
  a_dm_end: assert property ($fell(cpu_stall) && $past(instr_cycle, 4)
    |-> dm_wr.en && instr_cycle) else $error("no byte write at table end");
  a_dm_cause: assert property (dm_wr.en |-> instr_cycle && !cpu_stall
    && $past(cpu_stall, 4)) else $error("byte write without table op");
  a_dm_pulse: assert property (dm_wr.en |=> !dm_wr.en) else $error("byte write too long");
  // latch readback only moves after a table read, never from a software write
  a_latch_ro: assert property ($past(cpu_req.sfr_addr) == SFR_TABLE_HIGH_BYTE_LATCH
    && $past(cpu_req.sfr_addr, 2) == SFR_TABLE_HIGH_BYTE_LATCH && !dm_wr.en && !$past(dm_wr.en)
    && !$past(dm_wr.en, 2) |-> $stable(sfr_rdata)) else $error("latch changed");
  a_prog_pins: assert property (prog_active && $past(prog_active)
    |-> cpu_stall && !port_a_bit_two_pin_oe) else $error("pins not handed over");
  c_table: cover property (dm_wr.en);
  c_prog: cover property (prog_active);
  c_branch: cover property (instr_cycle && $past(cpu_req.branch));
endmodule : pmtr_asserts

bind pmtr_program_memory pmtr_asserts pmtr_asserts_i (.sys_clk, .rst_n, .cpu_req,
  .fetch_addr, .instr_cycle, .cpu_stall, .dm_wr, .sfr_rdata, .port_a_bit_two_pin_oe,
  .prog_active);

/* bench/pmtr_icp_writer.sv */
`timescale 1ns/1ps
module pmtr_icp_writer (
  output logic ck,
  output logic dat,
  input wire logic din
);
  // clock rests low between frames
  initial begin
    ck = 1'b0;
    dat = 1'b0;
  end
  // frame: command, 10 address bits, 16 data bits, msb first, change while clock low
  task automatic frame(input logic rd, input logic [9:0] a, input logic [15:0] d,
      output logic [15:0] q);
    logic [26:0] bits;
    bits = {rd, a, d};
    q = '0;
    for (int i = 26; i >= 0; i--) begin
      if (rd && i < 16)
        dat = ~din; // released: inverse, so a stale level never passes
      else
        dat = bits[i];
      #400;
      ck = 1'b1;
      if (rd && i < 16)
        q = {q[14:0], din};
      #400;
      ck = 1'b0;
    end
    dat = ~dat;
  endtask : frame
endmodule : pmtr_icp_writer

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pmtr_pkg::*;
  logic sys_clk, rst_n, prog_entry, pin0_out, pin0_oe, pin2_out, pin2_oe, wr_ck, wr_dat;
  logic instr_cycle, cpu_stall, prog_active, pin0_wire, pin2_wire;
  logic [9:0] fetch_addr;
  logic [15:0] fetch_word, rq;
  logic [7:0] sfr_rdata;
  logic [1:0] gpio_in;
  pmtr_cpu_req_s cpu_req, idle;
  pmtr_gpio_s gpio_drive;
  pmtr_dm_wr_s dm_wr;
  int err_total, cmp_count, ncyc;
  // only the device and the writer ever drive the two pins
  assign pin0_wire = pin0_oe ? pin0_out : wr_dat;
  assign pin2_wire = pin2_oe ? pin2_out : wr_ck;
  pmtr_program_memory pmtr_program_memory_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .cpu_req(cpu_req), .gpio_drive(gpio_drive), .prog_entry(prog_entry),
    .port_a_bit_zero_pin_in(pin0_wire), .port_a_bit_zero_pin_out(pin0_out),
    .port_a_bit_zero_pin_oe(pin0_oe), .port_a_bit_two_pin_in(pin2_wire),
    .port_a_bit_two_pin_out(pin2_out), .port_a_bit_two_pin_oe(pin2_oe),
    .fetch_addr(fetch_addr), .fetch_word(fetch_word), .instr_cycle(instr_cycle),
    .cpu_stall(cpu_stall), .dm_wr(dm_wr), .sfr_rdata(sfr_rdata), .gpio_in(gpio_in),
    .prog_active(prog_active));
  pmtr_icp_writer pmtr_icp_writer_i (.ck(wr_ck), .dat(wr_dat), .din(pin0_wire));
  // 25 mhz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // bounded wait for the next boundary, holding nxt on the core request
  task automatic wait_ic(input pmtr_cpu_req_s nxt);
    for (ncyc = 1; ncyc <= 12; ncyc++) begin
      @(posedge sys_clk);
      cpu_req <= nxt;
      #1;
      if (instr_cycle === 1'b1) break;
    end
    if (ncyc > 12) begin
      err_total++;
      results();
    end
  endtask : wait_ic
  task automatic wait_prog(input logic v);
    int i;
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      if (prog_active === v) break;
    end
    if (i == 10) begin
      err_total++;
      results();
    end
  endtask : wait_prog
  task automatic issue(input pmtr_cpu_req_s r);
    @(posedge sys_clk);
    cpu_req <= r;
    wait_ic(r);
  endtask : issue
  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    pmtr_cpu_req_s r;
    r = idle;
    r.sfr_we = 1'b1;
    r.sfr_addr = a;
    r.sfr_wdata = d;
    issue(r);
    wait_ic(idle);
  endtask : wr_sfr
  // one table read: stall, byte write, then latch seen through its register
  task automatic tbl(input logic last, input logic [7:0] dest, input logic [15:0] w);
    pmtr_cpu_req_s r;
    r = idle;
    r.tbl_req = 1'b1;
    r.tbl_last = last;
    r.tbl_dest = dest;
    issue(r);
    chk(16'(cpu_stall), 16'h0001);
    wait_ic(idle);
    chk(16'(ncyc), 16'h0004);
    chk({dm_wr.en, 7'h00, dm_wr.addr}, {1'b1, 7'h00, dest});
    chk(16'(dm_wr.data), 16'(w[7:0]));
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    chk(16'(sfr_rdata), 16'(w[15:8]));
  endtask : tbl
  task automatic t_prog();
    chk({15'h0000, pin2_oe}, 16'h0001);
    chk({12'h000, gpio_in, pin0_out, pin2_out}, 16'h0006);
    @(posedge sys_clk);
    prog_entry <= 1'b1;
    wait_prog(1'b1);
    #200;
    chk({14'h0000, pin2_oe, cpu_stall}, 16'h0001);
    pmtr_icp_writer_i.frame(1'b0, 10'h206, 16'h1234, rq);
    pmtr_icp_writer_i.frame(1'b0, 10'h306, 16'hab1a, rq);
    pmtr_icp_writer_i.frame(1'b0, 10'h3ff, 16'hc3e1, rq);
    pmtr_icp_writer_i.frame(1'b1, 10'h306, 16'h0000, rq);
    chk(rq, 16'hab1a);
    @(posedge sys_clk);
    prog_entry <= 1'b0;
    wait_prog(1'b0);
    $display("programming test done");
  endtask : t_prog
  // high pointer fe: only its two low bits reach the address
  task automatic t_table();
    wr_sfr(SFR_TBLP, 8'h06);
    wr_sfr(SFR_TBHP, 8'hfe);
    tbl(1'b0, 8'h61, 16'h1234);
    tbl(1'b1, 8'h62, 16'hab1a);
    wr_sfr(SFR_TABLE_HIGH_BYTE_LATCH, 8'h55);
    @(posedge sys_clk);
    #1;
    chk(16'(sfr_rdata), 16'h00ab);
    $display("table read test done");
  endtask : t_table
  task automatic t_branch();
    pmtr_cpu_req_s r;
    r = idle;
    r.branch = 1'b1;
    r.branch_addr = 10'h3ff;
    issue(r);
    chk(16'(fetch_addr), 16'h03ff);
    wait_ic(idle);
    chk(fetch_word, 16'hc3e1);
    chk(16'(fetch_addr), 16'h0000);
    $display("branch fetch test done");
  endtask : t_branch
  // main sequence; latch address held on the core bus while idle
  initial begin
    rst_n = 1'b0;
    prog_entry = 1'b0;
    idle = '0;
    idle.sfr_addr = SFR_TABLE_HIGH_BYTE_LATCH;
    cpu_req = idle;
    gpio_drive = 4'hd;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    chk(16'(fetch_addr), 16'h0000);
    rst_n <= 1'b1;
    wait_ic(idle);
    chk(16'(fetch_addr), 16'h0001);
    $display("reset test done");
    t_prog();
    t_table();
    t_branch();
    results();
  end
endmodule : tb_top

/* core/pmtr_icp_link.sv */
`timescale 1ns/1ps
module pmtr_icp_link (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic prog_active,
  input wire logic prog_serial_data_line,
  input wire logic prog_serial_clock_line,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output pmtr_pkg::pmtr_icp_req_s req,
  output logic data_out,
  output logic data_oe
);
  import pmtr_pkg::*;

  typedef struct packed {
    logic clk_prev;
    logic [4:0] bit_cnt;
    logic cmd_rd;
    logic [9:0] addr;
    logic [15:0] shift;
    logic out;
    logic oe;
    pmtr_icp_req_s req;
  } pmtr_link_state_s;

  pmtr_link_state_s st_reg;
  pmtr_link_state_s st_next;

  logic clk_rise;
  logic clk_fall;

  // both line inputs arrive already synchronised
  assign clk_rise = prog_serial_clock_line & ~st_reg.clk_prev;
  assign clk_fall = ~prog_serial_clock_line & st_reg.clk_prev;

  // frame decoder: command bit, address msb first, then data msb first
  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = prog_serial_clock_line;
    st_next.req.wr = 1'b0;
    st_next.req.rd = 1'b0;
    if (!prog_active) begin
      st_next.bit_cnt = 5'h00;
      st_next.oe = 1'b0;
    end else begin
      if (rd_valid) begin
        st_next.shift = rd_data;
      end
      if (clk_rise) begin
        if (st_reg.bit_cnt == 5'h00) begin
          st_next.cmd_rd = prog_serial_data_line;
        end else if (st_reg.bit_cnt <= ICP_ADDR_LAST) begin
          st_next.addr = {st_reg.addr[8:0], prog_serial_data_line};
        end else if (!st_reg.cmd_rd) begin
          st_next.shift = {st_reg.shift[14:0], prog_serial_data_line};
        end
        if (st_reg.bit_cnt == ICP_ADDR_LAST && st_reg.cmd_rd) begin
          st_next.req.rd = 1'b1;
          st_next.req.addr = {st_reg.addr[8:0], prog_serial_data_line};
        end
        if (st_reg.bit_cnt == ICP_FRAME_LAST) begin
          st_next.bit_cnt = 5'h00;
          st_next.oe = 1'b0; // hand the line back to the writer
          if (!st_reg.cmd_rd) begin
            st_next.req.wr = 1'b1;
            st_next.req.addr = st_reg.addr;
            st_next.req.wdata = {st_reg.shift[14:0], prog_serial_data_line};
          end
        end else begin
          st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
        end
      end
      // upload: change the line on falling edges so the writer samples on rising
      if (clk_fall && st_reg.cmd_rd && st_reg.bit_cnt > ICP_ADDR_LAST) begin
        st_next.out = st_reg.shift[15];
        st_next.shift = {st_reg.shift[14:0], 1'b0};
        st_next.oe = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req = st_reg.req;
  assign data_out = st_reg.out;
  assign data_oe = st_reg.oe;

endmodule : pmtr_icp_link

/* core/pmtr_program_memory.sv */
`timescale 1ns/1ps
// Contract
// - The program store holds 1024 words of 16 bits for code, table data and vectors.
// - Fetches use the program counter while table reads use their own pointer.
// - After reset the program counter is zero and execution starts there.
// - The table address is built from the low and the high table pointer.
// - A table read writes the low byte of the word to the operand data register.
// - A table read loads the high byte of the word into the high-byte latch.
// - Latch bits that the program word does not supply read as zero.
// - The last-page table read uses page 300h with the low pointer as offset.
// - The high-byte latch is read-only; software writes to it are ignored.
// - Every table instruction takes two instruction cycles, stalling the core once.
// - Programming moves data both ways on one data line clocked by the writer.
// - While programming, the two shared port pins become the data and clock lines.
module pmtr_program_memory (
  input wire logic sys_clk,
  input wire logic rst_n,
  input pmtr_pkg::pmtr_cpu_req_s cpu_req,
  input pmtr_pkg::pmtr_gpio_s gpio_drive,
  input wire logic prog_entry,
  input wire logic port_a_bit_zero_pin_in,
  output logic port_a_bit_zero_pin_out,
  output logic port_a_bit_zero_pin_oe,
  input wire logic port_a_bit_two_pin_in,
  output logic port_a_bit_two_pin_out,
  output logic port_a_bit_two_pin_oe,
  output logic [9:0] fetch_addr,
  output logic [15:0] fetch_word,
  output logic instr_cycle,
  output logic cpu_stall,
  output pmtr_pkg::pmtr_dm_wr_s dm_wr,
  output logic [7:0] sfr_rdata,
  output logic [1:0] gpio_in,
  output logic prog_active
);
  import pmtr_pkg::*;

  typedef struct packed {
    logic prog_meta;
    logic prog_sync;
    logic pa0_meta;
    logic pa0_sync;
    logic pa2_meta;
    logic pa2_sync;
    logic [1:0] phase;
    logic instr_cycle;
    logic [9:0] pc;
    logic [15:0] fetch_word;
    logic [7:0] tblp;
    logic [7:0] tbhp;
    logic [7:0] table_high_byte_latch;
    pmtr_tbl_state_e tstate;
    logic [9:0] tbl_addr;
    logic [7:0] tbl_dest;
    logic stall;
    pmtr_dm_wr_s dm_wr;
    logic [7:0] sfr_rdata;
    logic prog_active;
    logic [15:0] icp_rdata;
    logic icp_rvalid;
    logic pa0_out;
    logic pa0_oe;
    logic pa2_out;
    logic pa2_oe;
  } pmtr_core_state_s;

  pmtr_core_state_s st_reg;
  pmtr_core_state_s st_next;

  // nonvolatile store, contents are not touched by reset
  logic [PM_DW-1:0] prog_mem [PM_DEPTH];

  pmtr_icp_req_s icp_req;
  logic icp_data_out;
  logic icp_data_oe;
  logic cycle_end;

  // table address: last page ignores the high pointer, else both pointers join
  function automatic logic [9:0] table_address(
    input logic last_page,
    input logic [7:0] low_ptr,
    input logic [7:0] high_ptr
  );
    logic [9:0] full;
    full = '0;
    if (last_page) begin
      full = LAST_PAGE_BASE | {2'b00, low_ptr};
    end else begin
      full[TBLP_LSB +: 8] = low_ptr;
      full[TBHP_LSB +: TBHP_USED_W] = high_ptr[TBHP_USED_W-1:0];
    end
    return full;
  endfunction : table_address

  // upper byte of a program word, zero filled where the word is too narrow
  function automatic logic [7:0] high_byte(input logic [PM_DW-1:0] word);
    logic [7:0] hb;
    hb = '0;
    hb[PM_DW-BYTE_W-1:0] = word[PM_DW-1:BYTE_W];
    return hb;
  endfunction : high_byte

  // software view of the table registers; unused addresses read zero
  function automatic logic [7:0] sfr_view(
    input logic [7:0] addr,
    input logic [7:0] low_ptr,
    input logic [7:0] high_ptr,
    input logic [7:0] latch
  );
    logic [7:0] val;
    val = SFR_UNMAPPED;
    unique case (addr)
      SFR_TBLP: val = low_ptr;
      SFR_TBHP: val = high_ptr;
      SFR_TABLE_HIGH_BYTE_LATCH: val = latch;
      default: val = SFR_UNMAPPED;
    endcase
    return val;
  endfunction : sfr_view

  assign cycle_end = (st_reg.phase == PHASE_LAST);

  // serial link logic; it only sees the synchronised pin levels
  pmtr_icp_link u_icp_link (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .prog_active(st_reg.prog_active),
    .prog_serial_data_line(st_reg.pa0_sync),
    .prog_serial_clock_line(st_reg.pa2_sync),
    .rd_data(st_reg.icp_rdata),
    .rd_valid(st_reg.icp_rvalid),
    .req(icp_req),
    .data_out(icp_data_out),
    .data_oe(icp_data_oe)
  );

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    // pins come from outside two flops before use, the mode request three flops
    st_next.prog_meta = prog_entry;
    st_next.prog_sync = st_reg.prog_meta;
    st_next.pa0_meta = port_a_bit_zero_pin_in;
    st_next.pa0_sync = st_reg.pa0_meta;
    st_next.pa2_meta = port_a_bit_two_pin_in;
    st_next.pa2_sync = st_reg.pa2_meta;
    st_next.prog_active = st_reg.prog_sync;

    st_next.instr_cycle = 1'b0;
    st_next.dm_wr.en = 1'b0;
    st_next.icp_rvalid = 1'b0;

    // clock divider: one instruction cycle per four system clocks
    st_next.phase = st_reg.phase + 2'h1;
    st_next.sfr_rdata = sfr_view(cpu_req.sfr_addr, st_reg.tblp, st_reg.tbhp, st_reg.table_high_byte_latch);

    if (st_reg.prog_active) begin
      // core is held while the writer owns the store
      st_next.stall = 1'b1;
      st_next.tstate = PMTR_TBL_IDLE;
      st_next.pc = RESET_VECTOR;
      st_next.phase = 2'h0;
      if (icp_req.rd) begin
        st_next.icp_rdata = prog_mem[icp_req.addr];
        st_next.icp_rvalid = 1'b1;
      end
    end else if (cycle_end) begin
      st_next.instr_cycle = 1'b1;
      // pointer writes from software; the latch address is not writable
      if (cpu_req.sfr_we) begin
        if (cpu_req.sfr_addr == SFR_TBLP) begin
          st_next.tblp = cpu_req.sfr_wdata;
        end
        if (cpu_req.sfr_addr == SFR_TBHP) begin
          st_next.tbhp = cpu_req.sfr_wdata;
        end
      end
      unique case (st_reg.tstate)
        PMTR_TBL_IDLE: begin
          if (cpu_req.tbl_req) begin
            // first instruction cycle: latch the address, hold the pc
            st_next.tbl_addr = table_address(cpu_req.tbl_last, st_reg.tblp, st_reg.tbhp);
            st_next.tbl_dest = cpu_req.tbl_dest;
            st_next.tstate = PMTR_TBL_READ;
            st_next.stall = 1'b1;
          end else begin
            // normal fetch at the program counter
            st_next.fetch_word = prog_mem[st_reg.pc];
            st_next.pc = cpu_req.branch ? cpu_req.branch_addr : st_reg.pc + 10'h001;
            st_next.stall = 1'b0;
          end
        end
        PMTR_TBL_READ: begin
          // second instruction cycle: deliver both bytes, release the core
          st_next.dm_wr.en = 1'b1;
          st_next.dm_wr.addr = st_reg.tbl_dest;
          st_next.dm_wr.data = prog_mem[st_reg.tbl_addr][BYTE_W-1:0];
          st_next.table_high_byte_latch = high_byte(prog_mem[st_reg.tbl_addr]);
          st_next.tstate = PMTR_TBL_IDLE;
          st_next.stall = 1'b0;
        end
      endcase
    end

    // shared pins: programming takes them over, otherwise the port drives them
    if (st_reg.prog_active) begin
      st_next.pa0_out = icp_data_out;
      st_next.pa0_oe = icp_data_oe;
      st_next.pa2_out = 1'b0;
      st_next.pa2_oe = 1'b0;
    end else begin
      st_next.pa0_out = gpio_drive.bit0_out;
      st_next.pa0_oe = gpio_drive.bit0_oe;
      st_next.pa2_out = gpio_drive.bit2_out;
      st_next.pa2_oe = gpio_drive.bit2_oe;
    end
  end

  // state register; pc comes out of reset at the reset vector
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.pc <= RESET_VECTOR;
      st_reg.tblp <= TBLP_RST;
      st_reg.tbhp <= TBHP_RST;
      st_reg.table_high_byte_latch <= TABLE_HIGH_BYTE_LATCH_RST;
      st_reg.tstate <= PMTR_TBL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // store writes come only from the programming link; no erase sequencing here
  always_ff @(posedge sys_clk) begin
    if (icp_req.wr && st_reg.prog_active) begin
      prog_mem[icp_req.addr] <= icp_req.wdata;
    end
  end

  assign port_a_bit_zero_pin_out = st_reg.pa0_out;
  assign port_a_bit_zero_pin_oe = st_reg.pa0_oe;
  assign port_a_bit_two_pin_out = st_reg.pa2_out;
  assign port_a_bit_two_pin_oe = st_reg.pa2_oe;
  assign fetch_addr = st_reg.pc;
  assign fetch_word = st_reg.fetch_word;
  assign instr_cycle = st_reg.instr_cycle;
  assign cpu_stall = st_reg.stall;
  assign dm_wr = st_reg.dm_wr;
  assign sfr_rdata = st_reg.sfr_rdata;
  assign gpio_in = {st_reg.pa2_sync, st_reg.pa0_sync};
  assign prog_active = st_reg.prog_active;

endmodule : pmtr_program_memory

/* shared/pmtr_pkg.sv */
package pmtr_pkg;

  // program store geometry
  localparam int PM_DEPTH = 1024;
  localparam int PM_AW = 10;
  localparam int PM_DW = 16;
  localparam int BYTE_W = 8;

  // fixed addresses in the program store
  localparam logic [9:0] RESET_VECTOR = 10'h000;
  localparam logic [9:0] LAST_PAGE_BASE = 10'h300;

  // pointer field positions inside the table address
  localparam int TBHP_USED_W = 2;
  localparam int TBLP_LSB = 0;
  localparam int TBHP_LSB = 8;

  // special function register addresses in data memory
  localparam logic [7:0] SFR_TBLP = 8'h07;
  localparam logic [7:0] SFR_TABLE_HIGH_BYTE_LATCH = 8'h08;
  localparam logic [7:0] SFR_TBHP = 8'h09;
  localparam logic [7:0] SFR_UNMAPPED = 8'h00;

  // reset values
  localparam logic [7:0] TBLP_RST = 8'h00;
  localparam logic [7:0] TBHP_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_BYTE_LATCH_RST = 8'h00;

  // four system clocks form one instruction cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // serial programming frame: 1 command bit, 10 address bits, 16 data bits
  localparam logic [4:0] ICP_ADDR_LAST = 5'h0a;
  localparam logic [4:0] ICP_FRAME_LAST = 5'h1a;

  typedef enum logic [0:0] {
    PMTR_TBL_IDLE = 1'b0,
    PMTR_TBL_READ = 1'b1
  } pmtr_tbl_state_e;

  // requests from the cpu core, sampled at the instruction cycle boundary, except sfr_addr, which also feeds sfr_rdata every clock
  typedef struct packed {
    logic branch;
    logic [9:0] branch_addr;
    logic tbl_req;
    logic tbl_last;
    logic [7:0] tbl_dest;
    logic sfr_we;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
  } pmtr_cpu_req_s;

  // normal port function driven by the core for the two shared pins
  typedef struct packed {
    logic bit0_out;
    logic bit0_oe;
    logic bit2_out;
    logic bit2_oe;
  } pmtr_gpio_s;

  // data memory write produced by a table read
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pmtr_dm_wr_s;

  // program store access from the serial programming link
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [15:0] wdata;
  } pmtr_icp_req_s;

endpackage : pmtr_pkg
